// file: cc_pkg.sv
// Constants, register map and mode codes of the capture/compare array unit
//==============================================================================
// Overview of operation
// - Sixteen registers: 0 to 11 capture or compare, 12 to 15 compare only
// - Resolution one cycle, eight when staggered
// - Two 16-bit timers, each with reload
// - Timer clock: prescaled system clock or auxiliary overflow
// - First timer may count external input events
// - Each register picks its timer; 0 to 11 also pick capture or compare
// - Twelve registers own a capture/compare pin
// - Mode zero: interrupt only, many per period
// - Mode one: pin toggles on every match
// - Mode two: interrupt only, once per period
// - Mode three: match sets pin, overflow clears
// - Double mode: two registers toggle one pin
// - Single-event option limits any compare mode to one
// - Capture stores allocated timer on pin edge
// - Each capture raises its own interrupt request
// - Capture edge: rising, falling or both
// - Compare registers checked continuously against timer
package cc_pkg;

  //==========================================================================
  // Sizes
  localparam int CHAN_N         = 16;
  localparam int PIN_N          = 12;
  localparam int TIMER_W        = 16;
  localparam int AW             = 8;
  localparam int STAGGER_CYCLES = 8;
  localparam int PRE_W          = 6;

  //==========================================================================
  // Byte offsets
  localparam logic [AW-1:0] OFF_CTRL     = 8'h00;
  localparam logic [AW-1:0] OFF_TIMER_A  = 8'h04;
  localparam logic [AW-1:0] OFF_RELOAD_A = 8'h08;
  localparam logic [AW-1:0] OFF_TIMER_B  = 8'h0C;
  localparam logic [AW-1:0] OFF_RELOAD_B = 8'h10;
  localparam logic [AW-1:0] OFF_STATUS   = 8'h14;
  localparam logic [AW-1:0] OFF_MASK     = 8'h18;
  localparam logic [AW-1:0] OFF_PINS     = 8'h1C;
  localparam logic [AW-1:0] CH_VAL_BASE  = 8'h40;
  localparam logic [AW-1:0] CH_MODE_BASE = 8'h80;

  //==========================================================================
  // Control register fields
  localparam int CTRL_RUN_A   = 0;
  localparam int CTRL_RUN_B   = 1;
  localparam int CTRL_STAGGER = 2;
  localparam int CSEL_A_LSB   = 4;
  localparam int CSEL_B_LSB   = 8;
  localparam int CSEL_W       = 3;

  // Clock source selections
  localparam logic [CSEL_W-1:0] CSEL_DIV1 = 3'h0;
  localparam logic [CSEL_W-1:0] CSEL_DIV4 = 3'h1;
  localparam logic [CSEL_W-1:0] CSEL_DIV16 = 3'h2;
  localparam logic [CSEL_W-1:0] CSEL_DIV64 = 3'h3;
  localparam logic [CSEL_W-1:0] CSEL_AUX  = 3'h4;
  localparam logic [CSEL_W-1:0] CSEL_EXT  = 3'h5;

  //==========================================================================
  // Channel mode register fields
  localparam int MODE_W      = 7;
  localparam int MODE_LSB    = 0;
  localparam int TSEL_BIT    = 3;
  localparam int EDGE_RISE   = 4;
  localparam int EDGE_FALL   = 5;
  localparam int SINGLE_BIT  = 6;
  localparam int DOUBLE_SPAN = 8;

  typedef enum logic [2:0] {
    MODE_OFF, MODE_CAPTURE, MODE_CMP0, MODE_CMP1, MODE_CMP2, MODE_CMP3, MODE_DOUBLE
  } cc_mode_t;

  //==========================================================================
  // Reset values and bus answers
  localparam logic [15:0]          RST_REG16 = 16'h0000;
  localparam logic [MODE_W-1:0]    RST_MODE  = 7'h00;
  localparam logic [31:0]          RST_WORD  = 32'h0000_0000;
  localparam logic [1:0]           RESP_OKAY   = 2'h0;
  localparam logic [1:0]           RESP_SLVERR = 2'h2;

endpackage

// file: cc_time_base.sv
// One 16-bit time base with reload on overflow
`timescale 1ns/1ns
module cc_time_base #(
  parameter int W = cc_pkg::TIMER_W
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  // Control
  input  wire logic         tick,
  input  wire logic         load_we,
  input  wire logic [W-1:0] load_val,
  input  wire logic [W-1:0] reload_val,
  // State
  output logic      [W-1:0] cnt,
  output logic              step,
  output logic              ovf
);
  import cc_pkg::*;

  //==========================================================================
  // Counter
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= '0;
    end else if (load_we) begin
      cnt <= load_val;
    end else if (tick) begin
      if (&cnt) begin
        cnt <= reload_val;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  // Step marks a fresh count value; compares act only then
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      step <= 1'b0;
      ovf  <= 1'b0;
    end else begin
      step <= tick && !load_we;
      ovf  <= tick && !load_we && (&cnt);
    end
  end

endmodule // cc_time_base

// file: capture_compare_array_unit.sv
// Capture/compare array with two time bases and AXI4-Lite registers
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
module capture_compare_array_unit #(
  parameter int TW = cc_pkg::TIMER_W
) (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       nrst,
  // AXI4-Lite write address
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [cc_pkg::AW-1:0]      awaddr,
  // AXI4-Lite write data
  input  wire logic                       wvalid,
  output logic                            wready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  // AXI4-Lite write response
  output logic                            bvalid,
  input  wire logic                       bready,
  output logic [1:0]                      bresp,
  // AXI4-Lite read
  input  wire logic                       arvalid,
  output logic                            arready,
  input  wire logic [cc_pkg::AW-1:0]      araddr,
  output logic                            rvalid,
  input  wire logic                       rready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  // Count sources
  input  wire logic                       auxiliary_timer_overflow,
  input  wire logic                       ext_count_a,
  // Capture/compare pins
  input  wire logic [cc_pkg::PIN_N-1:0]   cc_pin_in,
  output logic      [cc_pkg::PIN_N-1:0]   cc_pin_out,
  output logic      [cc_pkg::PIN_N-1:0]   cc_pin_oe,
  // Interrupt
  output logic                            irq
);
  import cc_pkg::*;

  //==========================================================================
  // Declarations
  logic [15:0]        ctrl_ff, reload_a_ff, reload_b_ff, status_ff, mask_ff;
  logic [TW-1:0]      val_ff [CHAN_N];
  logic [MODE_W-1:0]  mode_ff [CHAN_N];
  logic [CHAN_N-1:0]  done_ff, spent_ff;
  logic [PIN_N-1:0]   pin_prev_ff, pin_out_ff, pin_oe_ff;
  logic               ext_prev_ff, irq_ff;
  logic [PRE_W-1:0]   pre_ff;
  logic               awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic               rd_pend_ff;
  logic [1:0]         bresp_ff, rresp_ff;
  logic [31:0]        rdata_ff, wdata_ff;
  logic [3:0]         wstrb_ff;
  logic [AW-1:0]      aw_addr_ff, ar_addr_ff;
  logic [TW-1:0]      cnt_a, cnt_b;
  logic               step_a, step_b, ovf_a, ovf_b;
  logic               tick_a, tick_b, stag_ok, ext_rise;
  logic               do_wr, do_rd, wr_ok;
  logic [31:0]        rd_data;
  logic               rd_ok;
  logic [CHAN_N-1:0]  act, cap, ch_ovf, wr_val, wr_mode;
  logic [TW-1:0]      cap_val [CHAN_N];
  logic [PIN_N-1:0]   tog, pset, pclr, nxt_oe;
  logic [15:0]        nxt_status;

  //==========================================================================
  // Helpers
  function automatic logic in_bank(input logic [AW-1:0] a, input logic [AW-1:0] base);
    return a[AW-1:AW-2] == base[AW-1:AW-2];
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic pre_tick(input logic [CSEL_W-1:0] sel,
                                    input logic [PRE_W-1:0]  pre,
                                    input logic              aux,
                                    input logic              ext);
    case (sel)
      CSEL_DIV1:  return 1'b1;
      CSEL_DIV4:  return &pre[1:0];
      CSEL_DIV16: return &pre[3:0];
      CSEL_DIV64: return &pre[5:0];
      CSEL_AUX:   return aux;
      CSEL_EXT:   return ext;
      default:    return 1'b0;
    endcase
  endfunction

  function automatic logic mapped(input logic [AW-1:0] a);
    return in_bank(a, CH_VAL_BASE) || in_bank(a, CH_MODE_BASE) ||
           (a[AW-1:5] == '0 && a[1:0] == 2'h0);
  endfunction

  //==========================================================================
  // AXI4-Lite slave handshakes
  assign do_wr = !awready_ff && !wready_ff && !bvalid_ff;
  assign do_rd = rd_pend_ff;
  assign wr_ok = mapped(aw_addr_ff);

  // Address and data are taken in either order; response follows both
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      aw_addr_ff <= '0;
      wdata_ff   <= RST_WORD;
      wstrb_ff   <= 4'h0;
    end else begin
      if (awvalid && awready_ff) begin
        aw_addr_ff <= awaddr;
        awready_ff <= 1'b0;
      end
      if (wvalid && wready_ff) begin
        wdata_ff  <= wdata;
        wstrb_ff  <= wstrb;
        wready_ff <= 1'b0;
      end
      if (do_wr) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && bready) begin
        bvalid_ff  <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff  <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      arready_ff <= 1'b1;
      rd_pend_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= RESP_OKAY;
      rdata_ff   <= RST_WORD;
      ar_addr_ff <= '0;
    end else begin
      rd_pend_ff <= 1'b0;
      if (arvalid && arready_ff) begin
        ar_addr_ff <= araddr;
        arready_ff <= 1'b0;
        rd_pend_ff <= 1'b1;
      end
      if (do_rd) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= rd_data;
        rresp_ff  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_ff && rready) begin
        rvalid_ff  <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  // Read multiplexer
  always_comb begin
    rd_data = RST_WORD;
    rd_ok   = mapped(ar_addr_ff);
    if (in_bank(ar_addr_ff, CH_VAL_BASE)) begin
      rd_data[TW-1:0] = val_ff[ar_addr_ff[5:2]];
    end else if (in_bank(ar_addr_ff, CH_MODE_BASE)) begin
      rd_data[MODE_W-1:0] = mode_ff[ar_addr_ff[5:2]];
    end else begin
      case (ar_addr_ff)
        OFF_CTRL:     rd_data[15:0] = ctrl_ff;
        OFF_TIMER_A:  rd_data[TW-1:0] = cnt_a;
        OFF_RELOAD_A: rd_data[15:0] = reload_a_ff;
        OFF_TIMER_B:  rd_data[TW-1:0] = cnt_b;
        OFF_RELOAD_B: rd_data[15:0] = reload_b_ff;
        OFF_STATUS:   rd_data[15:0] = status_ff;
        OFF_MASK:     rd_data[15:0] = mask_ff;
        OFF_PINS:     rd_data = {4'h0, cc_pin_in, 4'h0, pin_out_ff};
        default:      rd_data = RST_WORD;
      endcase
    end
  end

  //==========================================================================
  // Global control registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff     <= RST_REG16;
      reload_a_ff <= RST_REG16;
      reload_b_ff <= RST_REG16;
      mask_ff     <= RST_REG16;
    end else if (do_wr) begin
      case (aw_addr_ff)
        OFF_CTRL:     ctrl_ff     <= merge16(ctrl_ff, wdata_ff, wstrb_ff);
        OFF_RELOAD_A: reload_a_ff <= merge16(reload_a_ff, wdata_ff, wstrb_ff);
        OFF_RELOAD_B: reload_b_ff <= merge16(reload_b_ff, wdata_ff, wstrb_ff);
        OFF_MASK:     mask_ff     <= merge16(mask_ff, wdata_ff, wstrb_ff);
        default:      ctrl_ff     <= ctrl_ff;
      endcase
    end
  end

  //==========================================================================
  // Count clock selection
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pre_ff      <= '0;
      ext_prev_ff <= 1'b0;
    end else begin
      pre_ff      <= pre_ff + 1'b1;
      ext_prev_ff <= ext_count_a;
    end
  end

  assign ext_rise = ext_count_a && !ext_prev_ff;
  // Staggered: timers step only once per eight cycles
  assign stag_ok  = !ctrl_ff[CTRL_STAGGER] ||
                    (pre_ff[2:0] == 3'(STAGGER_CYCLES - 1));
  assign tick_a = ctrl_ff[CTRL_RUN_A] && stag_ok &&
                  pre_tick(ctrl_ff[CSEL_A_LSB +: CSEL_W], pre_ff,
                           auxiliary_timer_overflow, ext_rise);
  // The second time base has no external count input
  assign tick_b = ctrl_ff[CTRL_RUN_B] && stag_ok &&
                  pre_tick(ctrl_ff[CSEL_B_LSB +: CSEL_W], pre_ff,
                           auxiliary_timer_overflow, 1'b0);

  //==========================================================================
  // Time bases
  cc_time_base #(.W(TW)) u_time_base_a (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .tick       (tick_a),
    .load_we    (do_wr && aw_addr_ff == OFF_TIMER_A),
    .load_val   (merge16(cnt_a, wdata_ff, wstrb_ff)),
    .reload_val (reload_a_ff),
    .cnt        (cnt_a),
    .step       (step_a),
    .ovf        (ovf_a)
  );

  cc_time_base #(.W(TW)) u_time_base_b (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .tick       (tick_b),
    .load_we    (do_wr && aw_addr_ff == OFF_TIMER_B),
    .load_val   (merge16(cnt_b, wdata_ff, wstrb_ff)),
    .reload_val (reload_b_ff),
    .cnt        (cnt_b),
    .step       (step_b),
    .ovf        (ovf_b)
  );

  //==========================================================================
  // Channel evaluation
  always_comb begin
    tog    = '0;
    pset   = '0;
    pclr   = '0;
    nxt_oe = '0;
    for (int i = 0; i < CHAN_N; i++) begin
      cc_mode_t md;
      logic     tsel, stp, once, cmp, rise, fall;
      logic [TW-1:0] cnt;
      rise = 1'b0;
      fall = 1'b0;
      md   = cc_mode_t'(mode_ff[i][MODE_LSB +: 3]);
      tsel = mode_ff[i][TSEL_BIT];
      cnt  = tsel ? cnt_b : cnt_a;
      stp  = tsel ? step_b : step_a;
      ch_ovf[i]  = tsel ? ovf_b : ovf_a;
      cap_val[i] = cnt;
      once = (md == MODE_CMP2) || (md == MODE_CMP3);
      cmp  = (md == MODE_CMP0) || (md == MODE_CMP1) || once || (md == MODE_DOUBLE);
      // A held timer value matches once, on its fresh step
      act[i] = cmp && stp && (cnt == val_ff[i]) &&
               !(once && done_ff[i] && !ch_ovf[i]) && !spent_ff[i];
      wr_val[i]  = do_wr && in_bank(aw_addr_ff, CH_VAL_BASE) &&
                   aw_addr_ff[5:2] == 4'(i);
      wr_mode[i] = do_wr && in_bank(aw_addr_ff, CH_MODE_BASE) &&
                   aw_addr_ff[5:2] == 4'(i);
      cap[i] = 1'b0;
      if (i < PIN_N) begin
        rise   = cc_pin_in[i] && !pin_prev_ff[i];
        fall   = !cc_pin_in[i] && pin_prev_ff[i];
        cap[i] = (md == MODE_CAPTURE) &&
                 ((mode_ff[i][EDGE_RISE] && rise) ||
                  (mode_ff[i][EDGE_FALL] && fall));
        if (act[i] && md == MODE_CMP1) begin
          tog[i] = !tog[i];
        end
        if (act[i] && md == MODE_CMP3) begin
          pset[i] = 1'b1;
        end
        if (md == MODE_CMP3 && ch_ovf[i] && !spent_ff[i]) begin
          pclr[i] = 1'b1;
        end
        if (md == MODE_CMP1 || md == MODE_CMP3 || md == MODE_DOUBLE) begin
          nxt_oe[i] = 1'b1;
        end
      end
      // Channels i and i+8 share pin i in double mode
      if (md == MODE_DOUBLE) begin
        nxt_oe[i % DOUBLE_SPAN] = 1'b1;
        if (act[i]) begin
          tog[i % DOUBLE_SPAN] = !tog[i % DOUBLE_SPAN];
        end
      end
    end
  end

  //==========================================================================
  // Channel registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < CHAN_N; i++) begin
        val_ff[i]  <= '0;
        mode_ff[i] <= RST_MODE;
      end
    end else begin
      for (int i = 0; i < CHAN_N; i++) begin
        if (cap[i]) begin
          val_ff[i] <= cap_val[i];
        end else if (wr_val[i]) begin
          val_ff[i] <= merge16(val_ff[i], wdata_ff, wstrb_ff);
        end
        if (wr_mode[i] && wstrb_ff[0]) begin
          mode_ff[i] <= wdata_ff[MODE_W-1:0];
        end
      end
    end
  end

  // Period and single-event bookkeeping
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      done_ff  <= '0;
      spent_ff <= '0;
    end else begin
      for (int i = 0; i < CHAN_N; i++) begin
        if (act[i]) begin
          done_ff[i] <= 1'b1;
        end else if (ch_ovf[i] || wr_mode[i]) begin
          done_ff[i] <= 1'b0;
        end
        if (wr_mode[i]) begin
          spent_ff[i] <= 1'b0;
        // Mode three stays armed until its overflow clear ends the pulse
        end else if (mode_ff[i][SINGLE_BIT] &&
                     ((act[i] && mode_ff[i][2:0] != MODE_CMP3) ||
                      (mode_ff[i][2:0] == MODE_CMP3 && ch_ovf[i] && done_ff[i]))) begin
          spent_ff[i] <= 1'b1;
        end
      end
    end
  end

  //==========================================================================
  // Pins
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_prev_ff <= '0;
      pin_out_ff  <= '0;
      pin_oe_ff   <= '0;
    end else begin
      pin_prev_ff <= cc_pin_in;
      pin_oe_ff   <= nxt_oe;
      for (int p = 0; p < PIN_N; p++) begin
        if (pset[p]) begin
          pin_out_ff[p] <= 1'b1;
        end else if (pclr[p]) begin
          pin_out_ff[p] <= 1'b0;
        end else begin
          pin_out_ff[p] <= pin_out_ff[p] ^ tog[p];
        end
      end
    end
  end

  //==========================================================================
  // Interrupt requests; mode zero touches no pin
  // A new event in the clearing read cycle survives the clear
  assign nxt_status = ((do_rd && ar_addr_ff == OFF_STATUS) ? RST_REG16 : status_ff) |
                      16'(act | cap);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      status_ff <= RST_REG16;
      irq_ff    <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      irq_ff    <= |(status_ff & mask_ff);
    end
  end

  //==========================================================================
  // Outputs
  assign awready    = awready_ff;
  assign wready     = wready_ff;
  assign bvalid     = bvalid_ff;
  assign bresp      = bresp_ff;
  assign arready    = arready_ff;
  assign rvalid     = rvalid_ff;
  assign rdata      = rdata_ff;
  assign rresp      = rresp_ff;
  assign cc_pin_out = pin_out_ff;
  assign cc_pin_oe  = pin_oe_ff;
  assign irq        = irq_ff;

endmodule // capture_compare_array_unit

// file: cc_props.sv
// Port assertions of the capture/compare array unit
`timescale 1ns/1ns
module cc_props (
  // Clock and reset
  input wire logic                     ref_clk,
  input wire logic                     nrst,
  // Register bus
  input wire logic                     awvalid,
  input wire logic                     awready,
  input wire logic                     wready,
  input wire logic                     bvalid,
  input wire logic                     bready,
  input wire logic [1:0]               bresp,
  input wire logic                     arvalid,
  input wire logic                     arready,
  input wire logic                     rvalid,
  input wire logic                     rready,
  input wire logic [31:0]              rdata,
  input wire logic [1:0]               rresp,
  // Pins and interrupt
  input wire logic [cc_pkg::PIN_N-1:0] cc_pin_out,
  input wire logic                     irq
);
  import cc_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  //==========================================================================
  // Bus answers
  a_bvalid_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rvalid_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  a_read_timing: assert property (arvalid && arready |=> !arready ##1 rvalid)
    else $error("read answer late");
  a_write_single: assert property (bvalid |-> !awready && !wready)
    else $error("second write taken");
  a_resp_code: assert property (bvalid |-> bresp == RESP_OKAY || bresp == RESP_SLVERR)
    else $error("bad write response");
  a_err_zero: assert property (rvalid && rresp == RESP_SLVERR |-> rdata == RST_WORD)
    else $error("error read carries data");
  a_upper_zero: assert property (rvalid |-> rdata[31:28] == 4'h0)
    else $error("upper read bits set");
  a_b_release: assert property (bvalid && bready |=> !bvalid)
    else $error("write response repeated");
  // Main scenarios
  c_write: cover property (awvalid && awready);
  c_err: cover property (rvalid && rresp == RESP_SLVERR);
  c_irq: cover property ($rose(irq));
  c_set3: cover property ($rose(cc_pin_out[3]));
endmodule // cc_props

// file: cc_pin_model.sv
// Pin side partner: capture levels and count pulses
`timescale 1ns/1ns
module cc_pin_model (
  // Clock
  input  wire logic                     ref_clk,
  // Bench commands
  input  wire logic [cc_pkg::PIN_N-1:0] drv,
  input  wire logic                     ext_req,
  input  wire logic                     aux_req,
  // Unit side
  input  wire logic [cc_pkg::PIN_N-1:0] cc_pin_out,
  input  wire logic [cc_pkg::PIN_N-1:0] cc_pin_oe,
  output logic      [cc_pkg::PIN_N-1:0] cc_pin_in,
  output logic                          ext_count_a,
  output logic                          auxiliary_timer_overflow
);
  import cc_pkg::*;
  // Unit wins wherever it drives the pin
  assign cc_pin_in = (cc_pin_oe & cc_pin_out) | (~cc_pin_oe & drv);
  // One-cycle pulses, one per request
  always @(posedge ref_clk) begin
    ext_count_a <= ext_req;
    auxiliary_timer_overflow <= aux_req;
  end
endmodule // cc_pin_model

// file: capture_compare_array_unit_test.sv
// Self-checking bench of the capture/compare array unit
`timescale 1ns/1ns
module capture_compare_array_unit_test;
  import cc_pkg::*;
  logic        ref_clk = 1'b0, nrst = 1'b0, ext_req = 1'b0, aux_req = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [11:0] drv = 12'h000, cc_pin_in, cc_pin_out, cc_pin_oe;
  logic [15:0] base;
  logic        awready, wready, bvalid, arready, rvalid, irq, ext_count_a;
  logic        auxiliary_timer_overflow;
  logic [1:0]  bresp, rresp;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          seed, failures = 0, samples_checked = 0;
  always #4 ref_clk = ~ref_clk;
  capture_compare_array_unit u_capture_compare_array_unit (.ref_clk, .nrst, .awvalid,
    .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid, .bready(1'b1),
    .bresp, .arvalid, .arready, .araddr, .rvalid, .rready(1'b1), .rdata, .rresp,
    .auxiliary_timer_overflow, .ext_count_a, .cc_pin_in, .cc_pin_out, .cc_pin_oe, .irq);
  cc_pin_model u_cc_pin_model (.ref_clk, .drv, .ext_req, .aux_req, .cc_pin_out,
    .cc_pin_oe, .cc_pin_in, .ext_count_a, .auxiliary_timer_overflow);
  //==========================================================================
  // Compare and verdict
  task chk(input logic [33:0] got, input logic [33:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task print_verdict;
    if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [33:0] ok(input logic [31:0] v);
    return {RESP_OKAY, v};
  endfunction
  // Bus answers come off the queues in order
  always @(posedge ref_clk) begin
    if (rvalid === 1'b1) chk({rresp, rdata}, rq.pop_front());
    if (bvalid === 1'b1) chk({32'h0000_0000, bresp}, {32'h0000_0000, bq.pop_front()});
  end
  //==========================================================================
  // Bus and pin tasks
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OKAY);
    bq.push_back(e);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
  endtask
  task rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (rvalid !== 1'b1);
  endtask
  // Gap of six cycles lets a match reach pins and status
  task tick(input int n);
    repeat (n) begin
      ext_req <= 1'b1;
      @(posedge ref_clk);
      ext_req <= 1'b0;
      repeat (6) @(posedge ref_clk);
    end
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    print_verdict;
  end
  //==========================================================================
  // Scenarios
  initial begin
    seed = 29;
    base = 16'($random(seed)) & 16'h7FFF;
    drv = 12'($random(seed)) & 12'hF00;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(OFF_CTRL, ok(RST_WORD));
    rd(OFF_MASK, ok(RST_WORD));
    rd(8'hC0, {RESP_SLVERR, RST_WORD});
    wr(8'hC0, 32'h0000_0001, RESP_SLVERR);
    wr(OFF_MASK, 32'h0000_FFFF);
    wr(CH_VAL_BASE, {16'h0000, base + 16'd2});
    wr(CH_MODE_BASE, 32'h0000_0003);
    wr(OFF_RELOAD_A, {16'h0000, base});
    wr(OFF_TIMER_A, 32'h0000_FFFF);
    wr(OFF_CTRL, 32'h0000_0453);
    tick(1);
    rd(OFF_TIMER_A, ok({16'h0000, base}));
    repeat (3) begin
      aux_req <= 1'b1;
      @(posedge ref_clk);
      aux_req <= 1'b0;
      repeat (2) @(posedge ref_clk);
    end
    rd(OFF_TIMER_B, ok(32'h0000_0003));
    tick(2);
    chk({33'h0, irq}, 34'h1);
    rd(OFF_PINS, ok({4'h0, drv | 12'h001, 4'h0, 12'h001}));
    rd(OFF_STATUS, ok(32'h0000_0001));
    rd(OFF_STATUS, ok(RST_WORD));
    // Capture on rise only, then on fall only
    wr(CH_MODE_BASE + 8'h04, 32'h0000_0011);
    wr(CH_MODE_BASE + 8'h08, 32'h0000_0021);
    drv <= drv | 12'h006;
    tick(1);
    drv <= drv & ~12'h004;
    repeat (6) @(posedge ref_clk);
    rd(CH_VAL_BASE + 8'h04, ok({16'h0000, base + 16'd2}));
    rd(CH_VAL_BASE + 8'h08, ok({16'h0000, base + 16'd3}));
    rd(OFF_STATUS, ok(32'h0000_0006));
    // Modes three, two and zero on one value, matched twice
    for (int i = 3; i < 6; i++) begin
      wr(CH_VAL_BASE + 8'(4 * i), {16'h0000, base + 16'd4});
      wr(CH_MODE_BASE + 8'(4 * i), 32'(i == 5 ? 2 : 8 - i));
    end
    tick(1);
    rd(OFF_PINS, ok({4'h0, drv | 12'h009, 4'h0, 12'h009}));
    rd(OFF_STATUS, ok(32'h0000_0038));
    wr(OFF_TIMER_A, {16'h0000, base + 16'd3});
    tick(1);
    rd(OFF_STATUS, ok(32'h0000_0020));
    wr(OFF_TIMER_A, 32'h0000_FFFF);
    tick(1);
    rd(OFF_PINS, ok({4'h0, drv | 12'h001, 4'h0, 12'h001}));
    // Double pair on pin six, single event on pin seven
    wr(CH_VAL_BASE + 8'h18, {16'h0000, base + 16'd1});
    wr(CH_MODE_BASE + 8'h18, 32'h0000_0006);
    wr(CH_VAL_BASE + 8'h38, {16'h0000, base + 16'd2});
    wr(CH_MODE_BASE + 8'h38, 32'h0000_0006);
    wr(CH_VAL_BASE + 8'h1C, {16'h0000, base + 16'd1});
    wr(CH_MODE_BASE + 8'h1C, 32'h0000_0043);
    tick(2);
    wr(OFF_TIMER_A, {16'h0000, base});
    tick(1);
    rd(OFF_PINS, ok({4'h0, drv | 12'h0C0, 4'h0, 12'h0C0}));
    // Staggered: forty edges after the load give five steps
    wr(OFF_CTRL, 32'h0000_0057);
    wr(OFF_TIMER_B, RST_WORD);
    repeat (38) @(posedge ref_clk);
    rd(OFF_TIMER_B, ok(32'h0000_0005));
    repeat (4) @(posedge ref_clk);
    print_verdict;
  end
endmodule // capture_compare_array_unit_test
bind capture_compare_array_unit cc_props u_cc_props (.ref_clk, .nrst, .awvalid, .awready,
  .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata,
  .rresp, .cc_pin_out, .irq);
